// ---- rtl/led_ctrl_consts.svh ----
// Constants of the LED sequencer control register bank.
// Assumes a 25 MHz system clock and a 32 kHz tick enable from a divider.
`ifndef LED_CTRL_CONSTS_SVH
`define LED_CTRL_CONSTS_SVH
`define ADDR_RUN_CTRL 8'h00
`define ADDR_MODE_SEL 8'h01
`define ADDR_BLUE_DUTY 8'h02
`define ADDR_GREEN_DUTY 8'h03
`define ADDR_RED_DUTY 8'h04
`define RST_REG8 8'h00
`define BIT_LOG_DIM 7
`define BIT_MASTER_ON 6
`define MODE_USED_MASK 8'h3f
`define CLK_HZ 25000000
`define TICK_HZ 32768
`define STARTUP_US 500
`define STARTUP_CYC ((`STARTUP_US * (`CLK_HZ / 1000)) / 1000)
`define SLOW_DIV (`CLK_HZ / `TICK_HZ)
`endif

// ---- rtl/led_ctrl_pkg.sv ----
// Types of the LED sequencer control register bank.
// Assumes the constants header is included by the users.
package led_ctrl_pkg;
  typedef enum logic [1:0] {
    EXEC_HOLD = 2'h0,
    EXEC_STEP = 2'h1,
    EXEC_RUN = 2'h2,
    EXEC_SINGLE = 2'h3
  } exec_type;
  typedef enum logic [1:0] {
    OP_DISABLED = 2'h0,
    OP_LOAD = 2'h1,
    OP_RUN = 2'h2,
    OP_DIRECT = 2'h3
  } op_type;
endpackage : led_ctrl_pkg

// ---- rtl/led_engine_control_regs.sv ----
// What this block does
// - Log dimming bit set means logarithmic PWM output, else linear.
// - Master on bit starts the internal startup sequence.
// - Enable pin low clears the master on bit.
// - Run control holds exec fields at bits 5:4, 3:2, 1:0.
// - Hold finishes current instruction then stops.
// - Program counter access only while the engine holds.
// - Step executes, increments counter, returns to hold.
// - Run executes continuously from the current counter.
// - Single execute runs one instruction, no increment, back to hold.
// - Exec fields take effect after 32 kHz synchronisation.
// - Mode fields per engine; 00 disables, 01 loads and resets counter.
// - Mode 10 runs by exec field; 11 is direct control.
// - Mode fields take effect after 32 kHz synchronisation.
// - Duty registers hold 8-bit direct-control PWM values.
// Register bank behind a simple byte port; assumes an I2C front end.
`include "led_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module led_engine_control_regs #(
  parameter int STARTUP_CYCLES = `STARTUP_CYC,
  parameter int TICK_DIV = `SLOW_DIV
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Enable pin, low forces master off
  input wire logic chip_enable_i,
  // Register port from the serial front end
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Chip state
  output logic startup_busy_o,
  output logic chip_active_o,
  output logic log_dim_o,
  // Per-engine effective state
  output logic [5:0] exec_eff_o,
  output logic [5:0] op_eff_o,
  output logic [2:0] engine_busy_o,
  // Channel PWM outputs
  output logic [7:0] blue_pwm_o,
  output logic [7:0] green_pwm_o,
  output logic [7:0] red_pwm_o
);
  logic [7:0] run_ctrl_q;
  logic [7:0] run_ctrl_d;
  logic [7:0] mode_q;
  logic [7:0] blue_q;
  logic [7:0] green_q;
  logic [7:0] red_q;
  logic [5:0] exec_q;
  logic [5:0] op_q;
  logic [31:0] start_cnt_q;
  logic tick;
  logic [2:0] done;
  logic [11:0] pc_all;
  logic wr_run;
  logic wr_mode;

  // Address decode
  assign wr_run = reg_wr_i && reg_addr_i == `ADDR_RUN_CTRL;
  assign wr_mode = reg_wr_i && reg_addr_i == `ADDR_MODE_SEL;

  slow_tick_div #(
    .DIV(TICK_DIV)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Next run control: host write, engine self-clear to hold, pin clear.
  // Self-clear targets only the written-back field of a finished engine.
  always_comb begin
    run_ctrl_d = run_ctrl_q;
    for (int e = 0; e < 3; e++) begin
      if (done[e]) begin
        run_ctrl_d[(5-2*e) -: 2] = led_ctrl_pkg::EXEC_HOLD;
      end
    end
    if (wr_run) begin
      run_ctrl_d = reg_wdata_i;
    end
    if (!chip_enable_i) begin
      run_ctrl_d[`BIT_MASTER_ON] = 1'b0;
    end
  end

  // Host registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      run_ctrl_q <= `RST_REG8;
      mode_q <= `RST_REG8;
      blue_q <= `RST_REG8;
      green_q <= `RST_REG8;
      red_q <= `RST_REG8;
    end else begin
      run_ctrl_q <= run_ctrl_d;
      if (wr_mode) begin
        mode_q <= reg_wdata_i & `MODE_USED_MASK;
      end
      if (reg_wr_i && reg_addr_i == `ADDR_BLUE_DUTY) begin
        blue_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `ADDR_GREEN_DUTY) begin
        green_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `ADDR_RED_DUTY) begin
        red_q <= reg_wdata_i;
      end
    end
  end

  // Self-clear mask of finished engines, engine 1 in the top field.
  // The slow copy must drop a finished step at once: the host copy
  // clears one cycle late, and the next tick would run the step twice.
  logic [5:0] exec_clr;
  logic [5:0] exec_d;
  assign exec_clr = {{2{done[0]}}, {2{done[1]}}, {2{done[2]}}};
  assign exec_d = (tick ? run_ctrl_q[5:0] : exec_q) & ~exec_clr;

  // Slow-domain copies; mode fields only move at a 32 kHz tick, exec fields also at an engine self-clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      exec_q <= 6'h00;
      op_q <= 6'h00;
    end else begin
      exec_q <= exec_d;
      if (tick) begin
        op_q <= mode_q[5:0];
      end
    end
  end

  // Startup sequence timer, rearmed by each master-on rise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run_ctrl_q[`BIT_MASTER_ON]) begin
      start_cnt_q <= 32'h0;
    end else if (start_cnt_q != 32'(STARTUP_CYCLES)) begin
      start_cnt_q <= start_cnt_q + 32'h1;
    end
  end
  assign startup_busy_o = run_ctrl_q[`BIT_MASTER_ON] &&
    start_cnt_q != 32'(STARTUP_CYCLES);
  assign chip_active_o = run_ctrl_q[`BIT_MASTER_ON] && !startup_busy_o;
  assign log_dim_o = run_ctrl_q[`BIT_LOG_DIM];

  // Three engines; engine 1 uses the top field
  for (genvar g = 0; g < 3; g++) begin : g_eng
    seq_engine #(
      .PC_W(4)
    ) u_eng (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_i(tick && chip_active_o),
      .exec_i(exec_q[(5-2*g) -: 2]),
      .op_i(op_q[(5-2*g) -: 2]),
      .pc_o(pc_all[4*g +: 4]),
      .busy_o(engine_busy_o[g]),
      .done_o(done[g])
    );
  end

  assign exec_eff_o = exec_q;
  assign op_eff_o = op_q;

  // Direct PWM outputs; log curve approximated by squaring the duty
  function automatic logic [7:0] shape(input logic [7:0] v,
                                       input logic lg);
    logic [15:0] sq;
    sq = v * v;
    return lg ? sq[15:8] : v;
  endfunction : shape

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      blue_pwm_o <= 8'h00;
      green_pwm_o <= 8'h00;
      red_pwm_o <= 8'h00;
    end else begin
      blue_pwm_o <= shape(blue_q, run_ctrl_q[`BIT_LOG_DIM]);
      green_pwm_o <= shape(green_q, run_ctrl_q[`BIT_LOG_DIM]);
      red_pwm_o <= shape(red_q, run_ctrl_q[`BIT_LOG_DIM]);
    end
  end

  // Read mux, unmapped reads zero
  always_comb begin
    unique case (reg_addr_i)
      `ADDR_RUN_CTRL: reg_rdata_o = run_ctrl_q;
      `ADDR_MODE_SEL: reg_rdata_o = mode_q;
      `ADDR_BLUE_DUTY: reg_rdata_o = blue_q;
      `ADDR_GREEN_DUTY: reg_rdata_o = green_q;
      `ADDR_RED_DUTY: reg_rdata_o = red_q;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  // Assertions; engine checks watch engine 1, the others share its logic

  // Pin low wins over any host write
  AST_PIN_CLEARS: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !chip_enable_i |=> !run_ctrl_q[`BIT_MASTER_ON])
    else $error("master on survived pin low");

  // Unused mode bits never stored
  AST_MODE_TOP: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    mode_q[7:6] == 2'h0)
    else $error("mode upper bits nonzero");

  // Exec copy moves only at a tick or by an engine self-clear
  AST_EXEC_SYNC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !tick && done == 3'h0 |=> $stable(exec_q))
    else $error("exec moved without tick");

  // Mode copy taken at each tick
  AST_OP_SYNC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    tick |=> op_q == $past(mode_q[5:0]))
    else $error("mode not taken at tick");

  // Host write lands whole while the pin is high
  AST_RUN_WR: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    wr_run && chip_enable_i |=> run_ctrl_q == $past(reg_wdata_i))
    else $error("run control write lost");

  // A finished step returns the host field to hold
  AST_DONE_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    done[0] && !wr_run |=> run_ctrl_q[5:4] == 2'h0)
    else $error("engine not returned to hold");

  // Master on starts the startup timer
  AST_STARTUP: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    $rose(run_ctrl_q[`BIT_MASTER_ON]) |-> startup_busy_o)
    else $error("startup not launched");

  // Linear mode passes the blue duty unchanged
  AST_DUTY: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !run_ctrl_q[`BIT_LOG_DIM] |=> blue_pwm_o == $past(blue_q))
    else $error("linear duty mismatch");

  // Linear mode passes the red duty unchanged
  AST_RED_DUTY: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !run_ctrl_q[`BIT_LOG_DIM] |=> red_pwm_o == $past(red_q))
    else $error("linear red duty mismatch");

  // Mode write stores the used bits only
  AST_MODE_WR: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    wr_mode |=> mode_q == ($past(reg_wdata_i) & `MODE_USED_MASK))
    else $error("mode write lost");

  // A bare read changes neither the mode nor the blue duty register
  AST_READ_QUIET: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    reg_rd_i && !reg_wr_i |=> $stable(mode_q) && $stable(blue_q))
    else $error("read disturbed a register");

  // Without master on the chip is neither starting nor active
  AST_MASTER_OFF: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !run_ctrl_q[`BIT_MASTER_ON] |-> !chip_active_o && !startup_busy_o)
    else $error("active without master on");

  // Counter stands still in hold outside load mode, so the host may touch it
  AST_PC_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    op_q[5:4] != led_ctrl_pkg::OP_LOAD &&
    exec_q[5:4] == led_ctrl_pkg::EXEC_HOLD |=> $stable(pc_all[3:0]))
    else $error("counter moved in hold");

  // Step advances the counter by one
  AST_STEP_INC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    tick && chip_active_o && op_q[5:4] == led_ctrl_pkg::OP_RUN &&
    exec_q[5:4] == led_ctrl_pkg::EXEC_STEP
    |=> pc_all[3:0] == $past(pc_all[3:0]) + 4'h1)
    else $error("step did not advance counter");

  // Step reports done for the self-clear
  AST_STEP_DONE: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    tick && chip_active_o && op_q[5:4] == led_ctrl_pkg::OP_RUN &&
    exec_q[5:4] == led_ctrl_pkg::EXEC_STEP |=> done[0])
    else $error("step did not finish");

  // Done clears the slow copy at once, so no second step
  AST_DONE_EXEC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    done[0] |=> exec_q[5:4] == led_ctrl_pkg::EXEC_HOLD)
    else $error("finished step still pending");

  // Run advances the counter at each tick
  AST_RUN_INC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    tick && chip_active_o && op_q[5:4] == led_ctrl_pkg::OP_RUN &&
    exec_q[5:4] == led_ctrl_pkg::EXEC_RUN
    |=> pc_all[3:0] == $past(pc_all[3:0]) + 4'h1)
    else $error("run did not advance counter");

  // Single execute leaves the counter alone
  AST_SINGLE_PC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    tick && chip_active_o && op_q[5:4] == led_ctrl_pkg::OP_RUN &&
    exec_q[5:4] == led_ctrl_pkg::EXEC_SINGLE |=> $stable(pc_all[3:0]))
    else $error("single execute moved counter");

  // Load mode resets the counter
  AST_LOAD_PC: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    op_q[5:4] == led_ctrl_pkg::OP_LOAD |=> pc_all[3:0] == 4'h0)
    else $error("load did not reset counter");

  // Only run mode lets the engine work
  AST_NOT_RUN: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    op_q[5:4] != led_ctrl_pkg::OP_RUN |-> !engine_busy_o[0])
    else $error("engine busy outside run mode");

  // Main scenarios
  COV_START: cover property (@(posedge ref_clk_i) $fell(startup_busy_o));
  COV_STEP: cover property (@(posedge ref_clk_i) done[0]);
  COV_LOG: cover property (@(posedge ref_clk_i) log_dim_o && blue_q != 8'h00);
  COV_DIRECT: cover property (@(posedge ref_clk_i)
    op_q[5:4] == led_ctrl_pkg::OP_DIRECT);
endmodule : led_engine_control_regs
`default_nettype wire

// ---- rtl/seq_engine.sv ----
// One sequencing engine: execution control of its program counter.
// Assumes exec and op inputs are already taken at the slow tick.
`include "led_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module seq_engine #(
  parameter int PC_W = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control from the slow domain
  input wire logic tick_i,
  input wire logic [1:0] exec_i,
  input wire logic [1:0] op_i,
  // Status
  output logic [PC_W-1:0] pc_o,
  output logic busy_o,
  output logic done_o
);
  logic [PC_W-1:0] pc_q;
  logic running;
  assign running = op_i == led_ctrl_pkg::OP_RUN;

  // One instruction per slow tick; step and single report done
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_q <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (op_i == led_ctrl_pkg::OP_LOAD) begin
        pc_q <= '0;
      end else if (tick_i && running) begin
        unique case (exec_i)
          led_ctrl_pkg::EXEC_HOLD: ;
          led_ctrl_pkg::EXEC_STEP: begin
            pc_q <= pc_q + 1'b1;
            done_o <= 1'b1;
          end
          led_ctrl_pkg::EXEC_RUN: pc_q <= pc_q + 1'b1;
          led_ctrl_pkg::EXEC_SINGLE: done_o <= 1'b1;
        endcase
      end
    end
  end
  assign pc_o = pc_q;
  assign busy_o = running && exec_i != led_ctrl_pkg::EXEC_HOLD;
endmodule : seq_engine
`default_nettype wire

// ---- rtl/slow_tick_div.sv ----
// Divider making a one-cycle enable pulse at the 32 kHz sequencer rate.
// Assumes a single free-running system clock.
`timescale 1ns/1ps
`default_nettype none
module slow_tick_div #(
  parameter int DIV = 763
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Tick
  output logic tick_o
);
  logic [15:0] cnt_q;

  // Count down, pulse at zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cnt_q == 16'h0000) begin
      cnt_q <= 16'(DIV - 1);
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign tick_o = (cnt_q == 16'h0000) && !rst_i;
endmodule : slow_tick_div
`default_nettype wire

// ---- testbench/host_model.sv ----
// Host-side model: byte writes and reads on the register port.
// Assumes the bench calls its tasks in order, one at a time.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int GAP = 24
) (
  // Clock
  input wire logic ref_clk_i,
  // Register port toward the device
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // Control writes wait first, so the slow domain has taken the last one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a <= 8'h01) repeat (GAP) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Released data shows no stale value
  endtask : wr

  // Read data is combinational; taken at the rising edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge ref_clk_i);
    d = reg_rdata_i;
    @(negedge ref_clk_i);
    reg_rd_o = 1'b0;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ---- testbench/led_engine_control_regs_bench.sv ----
// Bench of the LED sequencer control register bank.
// Assumes short startup and tick parameters set below.
`timescale 1ns/1ps
`default_nettype none
module led_engine_control_regs_bench;
  localparam int SU = 20;
  localparam int TD = 4;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic chip_enable_i = 1'b1;
  logic reg_wr, reg_rd, busy, active, log_dim;
  logic [7:0] addr, wdata, rdata, b_pwm, g_pwm, r_pwm, v;
  logic [5:0] exec_eff, op_eff;
  logic [2:0] eng_busy;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock and hang guard
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  host_model #(.GAP(24)) host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata));
  led_engine_control_regs #(.STARTUP_CYCLES(SU), .TICK_DIV(TD)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .chip_enable_i(chip_enable_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .startup_busy_o(busy),
    .chip_active_o(active), .log_dim_o(log_dim), .exec_eff_o(exec_eff),
    .op_eff_o(op_eff), .engine_busy_o(eng_busy), .blue_pwm_o(b_pwm),
    .green_pwm_o(g_pwm), .red_pwm_o(r_pwm));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : idle

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_i = 1'b0;
    for (int a = 0; a < 6; a++) rchk(8'(a), 8'h00);
    $display("reset values done");
    host.wr(8'h02, 8'ha5);
    host.wr(8'h03, 8'h5a);
    host.wr(8'h04, 8'hff);
    rchk(8'h02, 8'ha5);
    chk(b_pwm, 8'ha5);
    chk(g_pwm, 8'h5a);
    host.wr(8'h00, 8'h80);
    idle(2);
    chk({7'h00, log_dim}, 8'h01);
    chk(b_pwm, 8'h6a);
    chk(g_pwm, 8'h1f);
    chk(r_pwm, 8'hfe);
    $display("duty and dimming done");
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h01, {2'b11, 2'(m), 2'(m), 2'(m)});
      rchk(8'h01, {2'b00, 2'(m), 2'(m), 2'(m)});
      idle(TD + 2);
      chk({2'h0, op_eff}, {2'b00, 2'(m), 2'(m), 2'(m)});
    end
    $display("mode codes done");
    host.wr(8'h01, 8'h2a);
    host.wr(8'h00, 8'h40);
    chk({6'h00, busy, active}, 8'h02);
    idle(SU + 2);
    chk({6'h00, busy, active}, 8'h01);
    for (int g = 0; g < 3; g++) begin
      host.wr(8'h00, 8'h40 | (8'h20 >> (2 * g)));
      idle(2 * TD + 2);
      chk({2'h0, exec_eff}, 8'h20 >> (2 * g));
      chk({5'h00, eng_busy}, 8'h01 << g);
    end
    host.wr(8'h00, 8'h40);
    idle(10 * TD);
    chk({5'h00, eng_busy}, 8'h00);
    host.wr(8'h00, 8'h50);
    idle(10 * TD);
    rchk(8'h00, 8'h40);
    host.wr(8'h00, 8'h70);
    idle(10 * TD);
    rchk(8'h00, 8'h40);
    $display("execution states done");
    chip_enable_i = 1'b0;
    idle(2);
    rchk(8'h00, 8'h00);
    chk({7'h00, active}, 8'h00);
    $display("enable pin done");
    close_out();
  end
endmodule : led_engine_control_regs_bench
`default_nettype wire
